// >>> dv/rre_exec_sva.sv
// Purpose: Port-level checks of the return/rotate executor
// Assumes: Sees only the top ports; one clock domain
// Notes: Instruction stalls are bounded from below only
`include "rre_regs.svh"
module rre_exec_sva
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic ctl_wr;
	////////////////////////////////////////
	// A control write answered at this edge issues an opcode
	assign ctl_wr = avs_write && !avs_waitrequest && {avs_address[5:2], 2'h0} == `RRE_OFF_CTRL;
	// Bus answers are single-cycle pulses tied to a held request
	chk_ans_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_ans_cause: assert property (!avs_waitrequest |-> avs_read || avs_write)
		else $error("answer without a request");
	chk_reset_hold: assert property ($rose(reset_n) |-> avs_waitrequest[*3])
		else $error("answer before internal reset release");
	// Running instructions hold off every access
	chk_ret_stall: assert property (ctl_wr && avs_writedata[15:1] == `RRE_RET_UPPER |=> avs_waitrequest[*8])
		else $error("return shorter than two instruction cycles");
	chk_rot_stall: assert property (ctl_wr && avs_writedata[15:10] == `RRE_ROT_UPPER |=> avs_waitrequest[*4])
		else $error("rotate shorter than one instruction cycle");
	chk_wr_settle: assert property (avs_write && !avs_waitrequest |=> avs_waitrequest[*2])
		else $error("write settle gap missing");
	// Read data move only when a read is answered
	chk_rd_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && avs_read)
		else $error("read data changed outside a read answer");
	chk_flags_width: assert property (!avs_waitrequest && avs_read && {avs_address[5:2], 2'h0} == `RRE_OFF_FLAGS
		|-> avs_readdata[31:5] == 27'h0)
		else $error("flags read shows bits above the field");
endmodule : rre_exec_sva

// >>> dv/rre_exec_tb.sv
// Purpose: Self-checking bench for the return/rotate executor
// Assumes: Avalon-MM master tasks; the slave paces every access
// Notes: Expected values come from the instruction behaviour only
`include "rre_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module rre_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	int error_cnt = 0;
	int total_checks = 0;
	logic [7:0] tv [4] = '{8'he6, 8'h80, 8'h41, 8'h7f};
	logic [2:0] tm [4] = '{3'h0, 3'h3, 3'h6, 3'h5};
	logic [7:0] tf [4] = '{8'h10, 8'h20, 8'h90, 8'h44};
	////////////////////////////////////////
	// 200 MHz core clock
	always #2.5 mclk = ~mclk;
	rre_exec rre_exec_i (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	// One access; the request is held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n++ < 300);
		q = avs_readdata;
		if (n >= 300)
			error_cnt++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Idle edge so no signal is driven twice in one step
		@(posedge mclk);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask : rc
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic c, d, a;
		logic [7:0] r;
		logic [11:0] fa;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		// Plain return: pop only, working state kept
		wr(`RRE_OFF_WREG, 32'h11);
		wr(`RRE_OFF_FLAGS, 32'h13);
		wr(`RRE_OFF_BANK, 32'h5);
		wr(`RRE_OFF_SH_W, 32'ha5);
		wr(`RRE_OFF_SH_FLAGS, 32'h0a);
		wr(`RRE_OFF_SH_BANK, 32'hc);
		wr(`RRE_OFF_PCLAT, 32'h1fab);
		wr(`RRE_OFF_STACK, 32'h1234a);
		wr(`RRE_OFF_CTRL, 32'h0012);
		rc("pc", `RRE_OFF_PC, 32'h1234a);
		rc("pclat", `RRE_OFF_PCLAT, 32'h1fab);
		rc("stkptr", `RRE_OFF_STKPTR, 32'h0);
		rc("wreg", `RRE_OFF_WREG, 32'h11);
		rc("flags", `RRE_OFF_FLAGS, 32'h13);
		rc("bank", `RRE_OFF_BANK, 32'h5);
		rc("ctrl", `RRE_OFF_CTRL, 32'h0);
		rc("unmapped", 6'h3c, 32'h0);
		$display("test return_plain done");
		// Shadow return, then a neighbouring opcode that must be ignored
		wr(`RRE_OFF_STACK, 32'h0abcd);
		wr(`RRE_OFF_CTRL, 32'h0013);
		rc("pc", `RRE_OFF_PC, 32'h0abcd);
		rc("wreg", `RRE_OFF_WREG, 32'ha5);
		rc("flags", `RRE_OFF_FLAGS, 32'h0a);
		rc("bank", `RRE_OFF_BANK, 32'hc);
		wr(`RRE_OFF_CTRL, 32'h0010);
		rc("ctrl", `RRE_OFF_CTRL, 32'h2);
		rc("pc", `RRE_OFF_PC, 32'h0abcd);
		$display("test return_shadow done");
		// Rotate cases over carry, destination and banking; bank-select is 3
		for (int i = 0; i < 4; i++)
		begin
			{c, d, a} = tm[i];
			r = {tv[i][6:0], c};
			fa = a ? {4'h3, tf[i]} : {tf[i][7] ? 4'hf : 4'h0, tf[i]};
			wr(`RRE_OFF_BANK, 32'h3);
			wr(`RRE_OFF_FLAGS, {31'h0, c});
			wr(`RRE_OFF_WREG, 32'h5a);
			wr(`RRE_OFF_FADDR, {20'h0, fa});
			wr(`RRE_OFF_FDATA, {24'h0, tv[i]});
			wr(`RRE_OFF_CTRL, {16'h0, 6'h0d, d, a, tf[i]});
			rc("flags", `RRE_OFF_FLAGS, {27'h0, r[7], 1'b0, r == 8'h00, 1'b0, tv[i][7]});
			rc("wreg", `RRE_OFF_WREG, {24'h0, d ? 8'h5a : r});
			rc("fdata", `RRE_OFF_FDATA, {24'h0, d ? r : tv[i]});
		end
		$display("test rotate done");
		print_verdict();
	end
	// Watchdog; the tests need well under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		print_verdict();
	end
endmodule : rre_exec_tb
bind rre_exec rre_exec_sva rre_exec_sva_i (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));

// >>> hdl/rre_exec.sv
// Purpose: Executes return-from-subroutine and rotate-left-through-carry over a register bus
// Assumes: One clock mclk at 200 MHz; four mclk phases make one instruction cycle
// Notes: Writing an opcode to the control register issues it; the bus stalls while it runs
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`include "rre_regs.svh"

// Overview of operation
// - Return opcode: upper fifteen bits fixed, low bit selects shadow restore.
// - Return pops the stack top into the PC; upper PC latches untouched.
// - With the option set, shadows reload working, flags and bank-select registers.
// - With the option clear, working, flags and bank-select registers keep contents.
// - Rotate shifts file register left through carry in one instruction cycle.
// - Destination bit 0 writes the working register; 1 writes the file register.
// - Banking bit 0 uses the access bank; 1 uses the bank-select register.
// - Result to working register leaves the file register unmodified.
module rre_exec
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	logic rst_meta_n, rst_n;
	rre_pkg::rre_state_t state;
	logic [1:0] phase;
	logic [15:0] op;
	logic [7:0] wreg, shadow_accumulator, pc_high_latch, result;
	rre_pkg::rre_flags_t flags, shadow_flags;
	logic [3:0] bank_select_reg, shadow_bank_select;
	rre_pkg::rre_pc_t pc;
	logic [4:0] pc_upper_latch, sp;
	logic [11:0] faddr;
	logic [1:0] settle;
	logic bad_op, carry_out, req, take, commit_wr, issue;
	rre_mem_if #(.DW(8), .AW(12)) fmem ();
	rre_mem_if #(.DW(21), .AW(5)) stk ();
	rre_mem #(.DW(8), .AW(12)) u_file (.clk(mclk), .port(fmem.mem));
	rre_mem #(.DW(21), .AW(5)) u_stack (.clk(mclk), .port(stk.mem));
	function automatic logic rre_is_ret(input logic [15:0] o);
		return o[15:1] == `RRE_RET_UPPER;
	endfunction : rre_is_ret
	function automatic logic rre_is_rot(input logic [15:0] o);
		return o[15:10] == `RRE_ROT_UPPER;
	endfunction : rre_is_rot
	// access bank override
	// Full file address from the operand byte and banking bit
	function automatic logic [11:0] rre_file_addr(input logic [15:0] o, input logic [3:0] bsel);
		if (o[8])
			return {bsel, o[7:0]};
		return {(o[7:0] < `RRE_ACC_SPLIT) ? `RRE_ACC_LOW_BANK : `RRE_ACC_HIGH_BANK, o[7:0]};
	endfunction : rre_file_addr
	////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: answer one cycle after the request is seen, never while busy
	assign req = avs_read | avs_write;
	// A request is taken only while idle and once the memories have settled
	assign take = req && avs_waitrequest && state == rre_pkg::RRE_IDLE && settle == 2'h0;
	assign commit_wr = avs_write & ~avs_waitrequest;
	assign issue = commit_wr && (avs_address & 6'h3c) == `RRE_OFF_CTRL;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !take;
	end
	// Memory read data lag their address; hold off the next answer until fresh
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			settle <= 2'h0;
		else if (commit_wr || state == rre_pkg::RRE_Q4)
			settle <= `RRE_SETTLE;
		else if (settle != 2'h0)
			settle <= settle - 2'h1;
	end
	// Read mux, captured only at the taking edge so the data stand until the next read answer
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata <= 32'h00000000;
		else if (take && avs_read)
			unique case (avs_address & 6'h3c)
				`RRE_OFF_CTRL: avs_readdata <= {30'h0, bad_op, state != rre_pkg::RRE_IDLE};
				`RRE_OFF_WREG: avs_readdata <= {24'h0, wreg};
				`RRE_OFF_FLAGS: avs_readdata <= {27'h0, flags};
				`RRE_OFF_BANK: avs_readdata <= {28'h0, bank_select_reg};
				`RRE_OFF_SH_W: avs_readdata <= {24'h0, shadow_accumulator};
				`RRE_OFF_SH_FLAGS: avs_readdata <= {27'h0, shadow_flags};
				`RRE_OFF_SH_BANK: avs_readdata <= {28'h0, shadow_bank_select};
				`RRE_OFF_PC: avs_readdata <= {11'h0, pc};
				`RRE_OFF_PCLAT: avs_readdata <= {19'h0, pc_upper_latch, pc_high_latch};
				`RRE_OFF_STACK: avs_readdata <= {11'h0, stk.rdata};
				`RRE_OFF_STKPTR: avs_readdata <= {27'h0, sp};
				`RRE_OFF_FADDR: avs_readdata <= {20'h0, faddr};
				`RRE_OFF_FDATA: avs_readdata <= {24'h0, fmem.rdata};
				default: avs_readdata <= 32'h00000000; // Unmapped
			endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: one-hot phases of the instruction cycle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= rre_pkg::RRE_IDLE;
			phase <= 2'h0;
		end
		else
		begin
			unique case (state)
				rre_pkg::RRE_IDLE:
				begin
					if (issue && (rre_is_ret(avs_writedata[15:0]) || rre_is_rot(avs_writedata[15:0])))
						state <= rre_pkg::RRE_Q1;
				end
				rre_pkg::RRE_Q1: state <= rre_pkg::RRE_Q2;
				rre_pkg::RRE_Q2: state <= rre_pkg::RRE_Q3;
				rre_pkg::RRE_Q3: state <= rre_pkg::RRE_Q4;
				rre_pkg::RRE_Q4:
				begin
					state <= rre_is_ret(op) ? rre_pkg::RRE_NOP : rre_pkg::RRE_IDLE;
					phase <= 2'h0;
				end
				rre_pkg::RRE_NOP:
				begin
					phase <= phase + 2'h1;
					if (phase == `RRE_Q_LAST)
						state <= rre_pkg::RRE_IDLE;
				end
				default: state <= rre_pkg::RRE_IDLE;
			endcase
		end
	end
	// Opcode latch and unsupported-opcode flag
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op <= `RRE_RST_OP;
			bad_op <= 1'b0;
		end
		else if (issue)
		begin
			op <= avs_writedata[15:0];
			bad_op <= !(rre_is_ret(avs_writedata[15:0]) || rre_is_rot(avs_writedata[15:0]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// File memory: bus window when idle, operand address while executing
	always_comb
	begin
		fmem.raddr = (state == rre_pkg::RRE_IDLE) ? faddr : rre_file_addr(op, bank_select_reg);
		fmem.we = 1'b0;
		fmem.waddr = faddr;
		fmem.wdata = avs_writedata[7:0];
		if (commit_wr && (avs_address & 6'h3c) == `RRE_OFF_FDATA)
			fmem.we = 1'b1;
		// file kept when result goes to working register
		if (state == rre_pkg::RRE_Q4 && rre_is_rot(op) && op[9])
		begin
			fmem.we = 1'b1;
			fmem.waddr = rre_file_addr(op, bank_select_reg);
			fmem.wdata = result;
		end
	end
	// Return stack: reads always look at the top entry; bus pushes write above it
	always_comb
	begin
		stk.raddr = sp - 5'h1;
		stk.we = commit_wr && (avs_address & 6'h3c) == `RRE_OFF_STACK;
		stk.waddr = sp;
		stk.wdata = avs_writedata[20:0];
	end
	// Stack pointer and PC
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp <= `RRE_RST_SP;
			pc <= `RRE_RST_PC;
		end
		else if (state == rre_pkg::RRE_Q4 && rre_is_ret(op))
		begin
			pc <= stk.rdata;
			sp <= sp - 5'h1;
		end
		else if (stk.we)
			sp <= sp + 5'h1;
		else if (commit_wr && (avs_address & 6'h3c) == `RRE_OFF_PC)
			pc <= avs_writedata[20:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Rotate datapath: operand arrives in Q3, result lands in Q4
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result <= `RRE_RST_BYTE;
			carry_out <= 1'b0;
		end
		else if (state == rre_pkg::RRE_Q3)
		begin
			result <= {fmem.rdata[6:0], flags[`RRE_FL_C]};
			carry_out <= fmem.rdata[7];
		end
	end
	// Working, flags and bank-select registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wreg <= `RRE_RST_BYTE;
			flags <= `RRE_RST_FLAGS;
			bank_select_reg <= `RRE_RST_BANK;
		end
		else if (state == rre_pkg::RRE_Q4 && rre_is_ret(op))
		begin
			if (op[0])
			begin
				wreg <= shadow_accumulator;
				flags <= shadow_flags;
				bank_select_reg <= shadow_bank_select;
			end
		end
		else if (state == rre_pkg::RRE_Q4 && rre_is_rot(op))
		begin
			if (!op[9])
				wreg <= result;
			flags[`RRE_FL_C] <= carry_out;
			flags[`RRE_FL_N] <= result[7];
			flags[`RRE_FL_Z] <= (result == 8'h00);
		end
		else if (commit_wr)
			unique case (avs_address & 6'h3c)
				`RRE_OFF_WREG: wreg <= avs_writedata[7:0];
				`RRE_OFF_FLAGS: flags <= avs_writedata[4:0];
				`RRE_OFF_BANK: bank_select_reg <= avs_writedata[3:0];
				default: ;
			endcase
	end
	// Software-owned registers: shadows, PC latches, file window address
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shadow_accumulator <= `RRE_RST_BYTE;
			shadow_flags <= `RRE_RST_FLAGS;
			shadow_bank_select <= `RRE_RST_BANK;
			pc_high_latch <= `RRE_RST_BYTE;
			pc_upper_latch <= 5'h00;
			faddr <= `RRE_RST_FADDR;
		end
		else if (commit_wr)
			unique case (avs_address & 6'h3c)
				`RRE_OFF_SH_W: shadow_accumulator <= avs_writedata[7:0];
				`RRE_OFF_SH_FLAGS: shadow_flags <= avs_writedata[4:0];
				`RRE_OFF_SH_BANK: shadow_bank_select <= avs_writedata[3:0];
				`RRE_OFF_PCLAT:
				begin
					pc_high_latch <= avs_writedata[7:0];
					pc_upper_latch <= avs_writedata[12:`RRE_PCLAT_UPPER_LSB];
				end
				`RRE_OFF_FADDR: faddr <= avs_writedata[11:0];
				default: ;
			endcase
	end
endmodule : rre_exec

// >>> hdl/rre_mem.sv
// Purpose: Small synchronous memory with registered read data
// Assumes: Read data appear one edge after the address
// Notes: Read during write returns the old word
module rre_mem #(parameter int DW = 8, parameter int AW = 12)
(
	input wire logic clk,
	rre_mem_if.mem port
);
	logic [DW-1:0] store [2**AW];

	// Write port
	always_ff @(posedge clk)
	begin
		if (port.we)
		begin
			store[port.waddr] <= port.wdata;
		end
	end

	// Registered read keeps the output off the array's combinational path
	always_ff @(posedge clk)
	begin
		port.rdata <= store[port.raddr];
	end
endmodule : rre_mem

// >>> hdl/rre_mem_if.sv
// Purpose: Port bundle between the executor and its memories
// Assumes: One write port and one registered read port
// Notes: Parameterised so the file memory and the return stack share it
interface rre_mem_if #(parameter int DW = 8, parameter int AW = 12);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport user (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rre_mem_if

// >>> hdl/rre_pkg.sv
// Purpose: Types shared by the return/rotate executor files
// Assumes: Constants live in rre_regs.svh
// Notes: Nothing here is imported; users write rre_pkg::name
package rre_pkg;
	typedef enum logic [5:0] {
		RRE_IDLE = 6'h01,
		RRE_Q1 = 6'h02,
		RRE_Q2 = 6'h04,
		RRE_Q3 = 6'h08,
		RRE_Q4 = 6'h10,
		RRE_NOP = 6'h20
	} rre_state_t;
	typedef logic [4:0] rre_flags_t;
	typedef logic [20:0] rre_pc_t;
endpackage : rre_pkg

// >>> hdl/rre_regs.svh
// Purpose: Offsets, field positions, reset values and opcode codes of the return/rotate executor
// Assumes: Byte addresses on the register bus, one 32-bit word per register
// Notes: Definitions only
`ifndef RRE_REGS_SVH
`define RRE_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define RRE_OFF_CTRL 6'h00
`define RRE_OFF_WREG 6'h04
`define RRE_OFF_FLAGS 6'h08
`define RRE_OFF_BANK 6'h0c
`define RRE_OFF_SH_W 6'h10
`define RRE_OFF_SH_FLAGS 6'h14
`define RRE_OFF_SH_BANK 6'h18
`define RRE_OFF_PC 6'h1c
`define RRE_OFF_PCLAT 6'h20
`define RRE_OFF_STACK 6'h24
`define RRE_OFF_STKPTR 6'h28
`define RRE_OFF_FADDR 6'h2c
`define RRE_OFF_FDATA 6'h30

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RRE_FL_C 0
`define RRE_FL_Z 2
`define RRE_FL_N 4
`define RRE_CTRL_BUSY 0
`define RRE_CTRL_BAD 1
`define RRE_PCLAT_UPPER_LSB 8

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RRE_RST_BYTE 8'h00
`define RRE_RST_FLAGS 5'h00
`define RRE_RST_BANK 4'h0
`define RRE_RST_PC 21'h000000
`define RRE_RST_SP 5'h00
`define RRE_RST_FADDR 12'h000
`define RRE_RST_OP 16'h0000

////////////////////////////////////////////////////////////////////////////////
// Opcodes, banking and timing counts
`define RRE_RET_UPPER 15'h0009
`define RRE_ROT_UPPER 6'h0d
`define RRE_ACC_SPLIT 8'h80
`define RRE_ACC_LOW_BANK 4'h0
`define RRE_ACC_HIGH_BANK 4'hf
`define RRE_Q_LAST 2'h3
`define RRE_SETTLE 2'h2

`endif
